/* hdl/conv_ctrl_pkg.sv */
// shared offsets, field layout, reset values and states of the converter sequencer
package conv_ctrl_pkg;
    // --------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // --------------------------------------------------------------------
    localparam logic [5:0] IDX_ENABLE_CONTROL = 6'h00;
    localparam logic [5:0] IDX_ACCUMULATION_CONTROL = 6'h01;
    localparam logic [5:0] IDX_CLOCK_REF_CONTROL = 6'h02;
    localparam logic [5:0] IDX_DELAY_CONTROL = 6'h03;
    localparam logic [5:0] IDX_WINDOW_MODE_CONTROL = 6'h04;
    localparam logic [5:0] IDX_SAMPLE_LENGTH_CONTROL = 6'h05;
    localparam logic [5:0] IDX_INPUT_SELECT = 6'h06;
    localparam logic [5:0] IDX_CONVERSION_COMMAND = 6'h08;
    localparam logic [5:0] IDX_EVENT_START_CONTROL = 6'h09;
    localparam logic [5:0] IDX_INTERRUPT_ENABLE = 6'h0a;
    localparam logic [5:0] IDX_INTERRUPT_FLAGS = 6'h0b;
    localparam logic [5:0] IDX_DEBUG_RUN_CONTROL = 6'h0c;
    localparam logic [5:0] IDX_RESULT = 6'h10;
    localparam logic [5:0] IDX_LOW_THRESHOLD = 6'h12;
    localparam logic [5:0] IDX_HIGH_THRESHOLD = 6'h14;

    // --------------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------------
    localparam int BIT_ENABLE = 0;
    localparam int BIT_START = 0;
    localparam int BIT_EVENT_EN = 0;
    localparam int BIT_DEBUG_RUN = 0;
    localparam int BIT_RESULT_READY = 0;
    localparam int BIT_WINDOW_MATCH = 1;
    localparam int BIT_AUTO_VARY = 4;
    localparam int REF_LSB = 4;

    // --------------------------------------------------------------------
    // reset values and codes
    // --------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [1:0] REF_INTERNAL = 2'h0;
    localparam logic [8:0] SAMPLE_BASE_CYCLES = 9'h002;
    localparam logic [2:0] WIN_NONE = 3'h0;
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_INSIDE = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;
    localparam logic [2:0] STARTUP_MAX_CODE = 3'h5;
    localparam logic [2:0] ACCUM_MAX_CODE = 3'h6;

    typedef enum logic [2:0] {
        st_idle,
        st_init,
        st_sample,
        st_convert,
        st_delay,
        st_done
    } state_t;
endpackage

/* hdl/conv_clock_divider.sv */
// converter clock enable derived from the peripheral clock
`timescale 1ns/10ps
module conv_clock_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] clock_divider_sel,
    output logic tick
);
    logic [7:0] count;
    wire [7:0] limit = 8'((9'h002 << clock_divider_sel) - 9'h001);
    wire at_limit = (count >= limit);

    // ------------------------------------------------------------
    // divide by 2, 4 ... 256
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            count <= 8'h00;
        else if (at_limit)
            count <= 8'h00;
        else
            count <= count + 8'h01;
    end

    assign tick = at_limit & ~rst;
endmodule

/* hdl/conv_sequencer.sv */
// converter sequencer: register file, start-up and sample timing, accumulation, window compare
`timescale 1ns/10ps
module conv_sequencer #(
    parameter int SAMPLE_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic event_in,
    input wire logic debug_halt,
    input wire logic deep_sleep_wake,
    input wire logic conv_done,
    input wire logic [SAMPLE_W-1:0] conv_data,
    output logic [4:0] mux_sel,
    output logic sample_open,
    output logic convert_req,
    output logic busy,
    output logic irq
);
    if (SAMPLE_W < 1 || SAMPLE_W > 10)
    begin : width_check
        $error("sample width must lie between 1 and 10");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] startup_cycles(input logic [2:0] code);
        // reserved codes give no delay
        if (code == 3'h0 || code > conv_ctrl_pkg::STARTUP_MAX_CODE)
            return 9'h000;
        return 9'h008 << code;
    endfunction

    function automatic logic [6:0] accum_target(input logic [2:0] code);
        if (code > conv_ctrl_pkg::ACCUM_MAX_CODE)
            return 7'h01;
        return 7'h01 << code;
    endfunction

    function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] value,
                                        input logic [15:0] low, input logic [15:0] high);
        case (mode)
            conv_ctrl_pkg::WIN_BELOW: return value < low;
            conv_ctrl_pkg::WIN_ABOVE: return value > high;
            conv_ctrl_pkg::WIN_INSIDE: return (value > low) && (value < high);
            conv_ctrl_pkg::WIN_OUTSIDE: return (value < low) || (value > high);
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic enable_bit;
    logic [2:0] accumulation_count;
    logic [2:0] clock_divider_sel;
    logic [1:0] ref_sel;
    logic [2:0] startup_delay_sel;
    logic auto_delay_vary_en;
    logic [3:0] inter_sample_delay;
    logic [2:0] window_mode_sel;
    logic [4:0] sample_length_ext;
    logic [4:0] input_select_field;
    logic event_start_enable;
    logic [1:0] interrupt_enable;
    logic window_match;
    logic result_ready;
    logic debug_run_bit;
    logic [15:0] result_value;
    logic [15:0] low_threshold;
    logic [15:0] high_threshold;
    logic ack;
    logic init_pending;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire [5:0] idx = address[7:2];
    wire req = read | write;
    assign waitrequest = req & ~ack;
    wire wr_acc = write & ~waitrequest;
    wire rd_acc = read & ~waitrequest;
    wire wr_lo = wr_acc & byteenable[0];
    wire wr_hi = wr_acc & byteenable[1];
    wire wr_enable = wr_lo && idx == conv_ctrl_pkg::IDX_ENABLE_CONTROL;
    wire wr_clock_ref = wr_lo && idx == conv_ctrl_pkg::IDX_CLOCK_REF_CONTROL;
    wire wr_delay = wr_lo && idx == conv_ctrl_pkg::IDX_DELAY_CONTROL;
    wire wr_command = wr_lo && idx == conv_ctrl_pkg::IDX_CONVERSION_COMMAND;
    wire wr_flags = wr_lo && idx == conv_ctrl_pkg::IDX_INTERRUPT_FLAGS;
    wire rd_result = rd_acc && idx == conv_ctrl_pkg::IDX_RESULT;
    wire [1:0] new_ref = writedata[conv_ctrl_pkg::REF_LSB +: 2];

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    conv_ctrl_pkg::state_t state;
    conv_ctrl_pkg::state_t next_state;
    logic [8:0] cnt;
    logic [8:0] next_cnt;
    logic [15:0] acc;
    logic [6:0] taken;
    logic tick;

    conv_clock_divider divider (
        .clk(clk),
        .rst(rst),
        .clock_divider_sel(clock_divider_sel),
        .tick(tick)
    );

    wire halted = debug_halt & ~debug_run_bit;
    wire step = tick & ~halted;
    wire idle = (state == conv_ctrl_pkg::st_idle);
    wire sw_start = wr_command & writedata[conv_ctrl_pkg::BIT_START];
    wire ev_start = event_in & event_start_enable & ~halted;
    // a start while busy is dropped: no queueing of a second measurement
    wire start_any = (sw_start | ev_start) & enable_bit;
    wire launch = start_any & idle & ~halted;
    wire [8:0] init_len = startup_cycles(startup_delay_sel);
    wire [8:0] sample_len = conv_ctrl_pkg::SAMPLE_BASE_CYCLES + 9'(sample_length_ext);
    wire last_sample = (taken + 7'h01 == accum_target(accumulation_count));
    wire got_sample = (state == conv_ctrl_pkg::st_convert) & conv_done;
    wire match = window_hit(window_mode_sel, acc, low_threshold, high_threshold);
    wire [15:0] next_acc = acc + 16'(conv_data);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            conv_ctrl_pkg::st_idle:
            begin
                if (launch && init_pending && init_len != 9'h000)
                begin
                    next_state = conv_ctrl_pkg::st_init;
                    next_cnt = init_len;
                end
                else if (launch)
                begin
                    next_state = conv_ctrl_pkg::st_sample;
                    next_cnt = sample_len;
                end
            end
            conv_ctrl_pkg::st_init, conv_ctrl_pkg::st_sample, conv_ctrl_pkg::st_delay:
            begin
                if (step && cnt == 9'h001)
                begin
                    next_state = (state == conv_ctrl_pkg::st_sample) ?
                        conv_ctrl_pkg::st_convert : conv_ctrl_pkg::st_sample;
                    next_cnt = sample_len;
                end
                else if (step)
                    next_cnt = cnt - 9'h001;
            end
            conv_ctrl_pkg::st_convert:
            begin
                if (conv_done && last_sample)
                    next_state = conv_ctrl_pkg::st_done;
                else if (conv_done && inter_sample_delay == 4'h0)
                begin
                    next_state = conv_ctrl_pkg::st_sample;
                    next_cnt = sample_len;
                end
                else if (conv_done)
                begin
                    next_state = conv_ctrl_pkg::st_delay;
                    next_cnt = 9'(inter_sample_delay);
                end
            end
            conv_ctrl_pkg::st_done:
                next_state = conv_ctrl_pkg::st_idle;
            default:
                next_state = conv_ctrl_pkg::st_idle;
        endcase
        if (!enable_bit)
            next_state = conv_ctrl_pkg::st_idle;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= conv_ctrl_pkg::st_idle;
            cnt <= 9'h000;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || launch)
        begin
            acc <= conv_ctrl_pkg::RESET_WORD;
            taken <= 7'h00;
        end
        else if (got_sample)
        begin
            acc <= next_acc;
            taken <= taken + 7'h01;
        end
    end

    // input held while a conversion runs, picked up again once idle
    always_ff @(posedge clk)
    begin
        if (rst)
            mux_sel <= 5'h00;
        else if (idle)
            mux_sel <= input_select_field;
    end

    // a new start-up delay is owed after enable, switch to internal reference or wake
    always_ff @(posedge clk)
    begin
        if (rst)
            init_pending <= 1'b0;
        else if ((wr_enable && writedata[conv_ctrl_pkg::BIT_ENABLE] && !enable_bit) ||
                 (wr_clock_ref && new_ref == conv_ctrl_pkg::REF_INTERNAL &&
                  ref_sel != conv_ctrl_pkg::REF_INTERNAL) || deep_sleep_wake)
            init_pending <= 1'b1;
        else if (state == conv_ctrl_pkg::st_init)
            init_pending <= 1'b0;
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable_bit <= 1'b0;
            accumulation_count <= 3'h0;
            clock_divider_sel <= 3'h0;
            ref_sel <= 2'h0;
            window_mode_sel <= 3'h0;
            sample_length_ext <= 5'h00;
            input_select_field <= 5'h00;
            event_start_enable <= 1'b0;
            interrupt_enable <= 2'h0;
            debug_run_bit <= 1'b0;
        end
        else if (wr_lo)
        begin
            case (idx)
                conv_ctrl_pkg::IDX_ENABLE_CONTROL: enable_bit <= writedata[0];
                conv_ctrl_pkg::IDX_ACCUMULATION_CONTROL: accumulation_count <= writedata[2:0];
                conv_ctrl_pkg::IDX_CLOCK_REF_CONTROL:
                begin
                    clock_divider_sel <= writedata[2:0];
                    ref_sel <= new_ref;
                end
                conv_ctrl_pkg::IDX_WINDOW_MODE_CONTROL: window_mode_sel <= writedata[2:0];
                conv_ctrl_pkg::IDX_SAMPLE_LENGTH_CONTROL: sample_length_ext <= writedata[4:0];
                conv_ctrl_pkg::IDX_INPUT_SELECT: input_select_field <= writedata[4:0];
                conv_ctrl_pkg::IDX_EVENT_START_CONTROL: event_start_enable <= writedata[0];
                conv_ctrl_pkg::IDX_INTERRUPT_ENABLE: interrupt_enable <= writedata[1:0];
                conv_ctrl_pkg::IDX_DEBUG_RUN_CONTROL: debug_run_bit <= writedata[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            startup_delay_sel <= 3'h0;
            auto_delay_vary_en <= 1'b0;
            inter_sample_delay <= 4'h0;
        end
        else if (wr_delay)
        begin
            startup_delay_sel <= writedata[7:5];
            auto_delay_vary_en <= writedata[conv_ctrl_pkg::BIT_AUTO_VARY];
            inter_sample_delay <= writedata[3:0];
        end
        else if (got_sample && auto_delay_vary_en)
            inter_sample_delay <= inter_sample_delay + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            low_threshold <= conv_ctrl_pkg::RESET_WORD;
            high_threshold <= conv_ctrl_pkg::RESET_WORD;
        end
        else
        begin
            if (wr_lo && idx == conv_ctrl_pkg::IDX_LOW_THRESHOLD)
                low_threshold[7:0] <= writedata[7:0];
            if (wr_hi && idx == conv_ctrl_pkg::IDX_LOW_THRESHOLD)
                low_threshold[15:8] <= writedata[15:8];
            if (wr_lo && idx == conv_ctrl_pkg::IDX_HIGH_THRESHOLD)
                high_threshold[7:0] <= writedata[7:0];
            if (wr_hi && idx == conv_ctrl_pkg::IDX_HIGH_THRESHOLD)
                high_threshold[15:8] <= writedata[15:8];
        end
    end

    // ------------------------------------------------------------
    // result and flags; a set in the clearing cycle wins
    // ------------------------------------------------------------
    wire done = (state == conv_ctrl_pkg::st_done);
    wire clr_ready = rd_result | (wr_flags & writedata[conv_ctrl_pkg::BIT_RESULT_READY]);
    wire clr_match = rd_result | (wr_flags & writedata[conv_ctrl_pkg::BIT_WINDOW_MATCH]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result_value <= conv_ctrl_pkg::RESET_WORD;
            result_ready <= 1'b0;
            window_match <= 1'b0;
        end
        else
        begin
            if (done)
                result_value <= acc;
            result_ready <= done | (result_ready & ~clr_ready);
            window_match <= (done & match) | (window_match & ~clr_match);
        end
    end

    assign irq = (result_ready & interrupt_enable[0]) |
                 (window_match & interrupt_enable[1]);
    assign busy = ~idle;
    assign sample_open = (state == conv_ctrl_pkg::st_sample) |
                         (state == conv_ctrl_pkg::st_delay);
    assign convert_req = (state == conv_ctrl_pkg::st_convert);

    // ------------------------------------------------------------
    // read side: one wait state, data registered
    // ------------------------------------------------------------
    logic [31:0] read_mux;

    always_comb
    begin
        read_mux = 32'h0000_0000;
        case (idx)
            conv_ctrl_pkg::IDX_ENABLE_CONTROL: read_mux[0] = enable_bit;
            conv_ctrl_pkg::IDX_ACCUMULATION_CONTROL: read_mux[2:0] = accumulation_count;
            conv_ctrl_pkg::IDX_CLOCK_REF_CONTROL: read_mux[7:0] = {2'h0, ref_sel, 1'b0,
                                                                   clock_divider_sel};
            conv_ctrl_pkg::IDX_DELAY_CONTROL: read_mux[7:0] = {startup_delay_sel,
                                                               auto_delay_vary_en,
                                                               inter_sample_delay};
            conv_ctrl_pkg::IDX_WINDOW_MODE_CONTROL: read_mux[2:0] = window_mode_sel;
            conv_ctrl_pkg::IDX_SAMPLE_LENGTH_CONTROL: read_mux[4:0] = sample_length_ext;
            conv_ctrl_pkg::IDX_INPUT_SELECT: read_mux[4:0] = input_select_field;
            conv_ctrl_pkg::IDX_CONVERSION_COMMAND: read_mux[0] = busy;
            conv_ctrl_pkg::IDX_EVENT_START_CONTROL: read_mux[0] = event_start_enable;
            conv_ctrl_pkg::IDX_INTERRUPT_ENABLE: read_mux[1:0] = interrupt_enable;
            conv_ctrl_pkg::IDX_INTERRUPT_FLAGS: read_mux[1:0] = {window_match, result_ready};
            conv_ctrl_pkg::IDX_DEBUG_RUN_CONTROL: read_mux[0] = debug_run_bit;
            conv_ctrl_pkg::IDX_RESULT: read_mux[15:0] = result_value;
            conv_ctrl_pkg::IDX_LOW_THRESHOLD: read_mux[15:0] = low_threshold;
            conv_ctrl_pkg::IDX_HIGH_THRESHOLD: read_mux[15:0] = high_threshold;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= req & ~ack;
            if (read && !ack)
                readdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence idle_launch_s;
        idle && sw_start && enable_bit && !halted;
    endsequence

    sequence sample_entry_s;
        state != conv_ctrl_pkg::st_sample ##1 state == conv_ctrl_pkg::st_sample;
    endsequence

    sw_start_a: assert property (idle_launch_s |=> busy)
        else $error("software start did not begin a measurement");
    busy_read_a: assert property (read && !ack && idx == conv_ctrl_pkg::IDX_CONVERSION_COMMAND
        && busy |=> readdata[0])
        else $error("start bit did not read as busy");
    ready_set_a: assert property (done |=> result_ready && busy == 1'b0)
        else $error("result ready not set at completion");
    ready_clear_a: assert property (wr_flags && writedata[0] && !done |=> !result_ready)
        else $error("result ready not cleared by write one");
    match_set_a: assert property (done && match |=> window_match)
        else $error("window match not flagged");
    irq_gate_a: assert property (window_match && interrupt_enable[1] |-> irq)
        else $error("window interrupt not raised");
    busy_ignore_a: assert property (state == conv_ctrl_pkg::st_convert && start_any
        && !conv_done && enable_bit |=> state == conv_ctrl_pkg::st_convert)
        else $error("start while busy disturbed conversion");
    delay_wrap_a: assert property (got_sample && auto_delay_vary_en && !wr_delay
        |=> inter_sample_delay == 4'($past(inter_sample_delay) + 4'h1))
        else $error("inter-sample delay did not step");
    sample_len_a: assert property (sample_entry_s |-> cnt == sample_len)
        else $error("sampling length wrong");
    halt_freeze_a: assert property (halted && state == conv_ctrl_pkg::st_init
        && enable_bit |=> $stable(cnt))
        else $error("sequencer ran while halted");
    mux_hold_a: assert property (busy && $past(busy) |-> $stable(mux_sel))
        else $error("input changed during conversion");
endmodule

/* tb/conv_core_model.sv */
// analog core model: ends a sample a set number of cycles after each request
`timescale 1ns/10ps
module conv_core_model (
    input wire logic clk,
    input wire logic convert_req,
    input wire logic [9:0] sample,
    input wire logic [3:0] lag,
    output logic conv_done,
    output logic [9:0] conv_data
);
    int n = 0;
    initial conv_done = 0;
    initial conv_data = 0;
    // data toggles outside the pulse, so a late capture shows up
    always @(posedge clk)
    begin
        conv_done <= 0;
        conv_data <= ~conv_data;
        n <= (convert_req && !conv_done) ? n + 1 : 0;
        if (convert_req && !conv_done && n >= lag)
        begin
            conv_done <= 1;
            conv_data <= sample;
        end
    end
endmodule

/* tb/adc_sequencer_control_bench.sv */
// bench: registers, conversions and window modes against an integer model
`timescale 1ns/10ps
module adc_sequencer_control_bench;
    logic clk = 0, rst = 1, read = 0, write = 0, event_in = 0, debug_halt = 0, dsw = 0;
    logic conv_done, sample_open, convert_req, busy, irq, waitrequest;
    logic [7:0] address = 0;
    logic [3:0] byteenable = 4'hf, lag = 4'h1;
    logic [31:0] writedata = 0, readdata, q;
    logic [9:0] conv_data, sample = 0;
    logic [4:0] mux_sel;
    int n_mismatch = 0, checks_done = 0, seed = 32'hcc33, acc = 0, base, r, m;
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        sample <= 10'($random(seed));
        if (conv_done && convert_req) acc <= acc + conv_data;
    end
    conv_sequencer dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .event_in(event_in),
        .debug_halt(debug_halt), .deep_sleep_wake(dsw), .conv_done(conv_done),
        .conv_data(conv_data), .mux_sel(mux_sel), .sample_open(sample_open),
        .convert_req(convert_req), .busy(busy), .irq(irq));
    conv_core_model core (.clk(clk), .convert_req(convert_req), .sample(sample),
        .lag(lag), .conv_done(conv_done), .conv_data(conv_data));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conv_wait();
        repeat (2) @(posedge clk);
        while (busy !== 1'b0) @(negedge clk);
        r = acc - base;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 0;
        for (m = 0; m < 13; m++)
        begin
            bus(0, 8'(m * 4), 0);
            chk(q, 0);
        end
        $display("reset values done");
        bus(1, 8'h00, 1);
        bus(1, 8'h04, 1);
        bus(1, 8'h10, 1);
        bus(1, 8'h48, 32'h0000_ffff);
        bus(1, 8'h28, 3);
        base = acc;
        bus(1, 8'h20, 1);
        bus(1, 8'h18, 32'h0000_001d);
        chk(mux_sel, 0);
        bus(0, 8'h20, 0);
        chk(q, 1);
        // a second start mid-conversion must not restart or extend the measurement
        bus(1, 8'h20, 1);
        conv_wait();
        bus(0, 8'h20, 0);
        chk(q, 0);
        chk(mux_sel, 32'h0000_001d);
        chk(irq, 1);
        bus(0, 8'h2c, 0);
        chk(q, 3);
        bus(0, 8'h40, 0);
        chk(q, r & 32'h0000_ffff);
        bus(0, 8'h2c, 0);
        chk(q, 0);
        chk(irq, 0);
        $display("accumulated conversion done");
        bus(1, 8'h04, 0);
        bus(1, 8'h24, 1);
        bus(1, 8'h48, 32'h0000_0100);
        bus(1, 8'h50, 32'h0000_0300);
        // auto variation on, delay at fifteen: five samples step it through the wrap
        bus(1, 8'h0c, 32'h0000_001f);
        for (m = 0; m < 5; m++)
        begin
            lag <= 4'(m * 3);
            bus(1, 8'h10, m);
            base = acc;
            @(posedge clk) event_in <= 1;
            @(posedge clk) event_in <= 0;
            conv_wait();
            bus(0, 8'h2c, 0);
            chk(q, {m == 1 && r < 256 || m == 2 && r > 768 || m == 3 && r > 256 && r < 768
                || m == 4 && (r < 256 || r > 768), 1'b1});
            bus(1, 8'h2c, 3);
            bus(0, 8'h2c, 0);
            chk(q, 0);
        end
        bus(0, 8'h0c, 0);
        chk(q, 32'h0000_0014);
        $display("window modes done");
        debug_halt <= 1;
        @(posedge clk) event_in <= 1;
        @(posedge clk) event_in <= 0;
        repeat (3) @(negedge clk);
        chk(busy, 0);
        $display("debug halt done");
        tally_and_finish();
    end
endmodule
